/* File: verilog/an_page_pkg.sv */
package an_page_pkg;
  // Register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PAGE_W = 48;
  localparam int TECH_W = 25;
  // Word offsets of the bank
  localparam logic [7:0] OFS_LOCAL_NP_LOW = 8'hC5;
  localparam logic [7:0] OFS_LOCAL_NP_HIGH = 8'hC6;
  localparam logic [7:0] OFS_PARTNER_BASE_LOW = 8'hC7;
  localparam logic [7:0] OFS_PARTNER_BASE_HIGH = 8'hC8;
  localparam logic [7:0] OFS_PARTNER_NP_LOW = 8'hC9;
  localparam logic [7:0] OFS_PARTNER_NP_HIGH = 8'hCA;
  localparam logic [7:0] OFS_PARTNER_ADV = 8'hCB;
  localparam logic [7:0] OFS_TRAIN_CTRL = 8'hD0;
  // Next page low flag positions
  localparam int NP_TOGGLE_BIT = 11;
  localparam int NP_ACK2_BIT = 12;
  localparam int NP_MSG_BIT = 13;
  localparam int NP_ACK_BIT = 14;
  localparam int NP_NEXT_BIT = 15;
  // Page bit positions inside a 48-bit codeword
  localparam int PAGE_LOW_MSB = 15;
  localparam int PAGE_HIGH_LSB = 16;
  localparam int PAGE_HIGH_MSB = 47;
  localparam int PAGE_BASE_HIGH_MSB = 45;
  localparam int CODE_PAUSE_LSB = 10;
  localparam int CODE_PAUSE_MSB = 12;
  localparam int CODE_RF_BIT = 13;
  localparam int CODE_TECH_LSB = 21;
  localparam int CODE_FEC_LSB = 46;
  // Partner ability register layout
  localparam int ADV_TECH_LSB = 0;
  localparam int ADV_FEC_LSB = 25;
  localparam int ADV_RF_BIT = 27;
  localparam int ADV_PAUSE_LSB = 28;
  // Technology ability bits the local PHY can run
  localparam int TECH_KX = 0;
  localparam int TECH_KR = 2;
  localparam logic [24:0] TECH_SUPPORTED = 25'h0000005;
  // Training control bits
  localparam int TRN_ENABLE_BIT = 0;
  localparam int TRN_NO_MAX_WAIT_BIT = 1;
  localparam int TRN_FAST_BIT = 2;
  localparam int TRN_MULTI_MIN_BIT = 3;
  localparam logic [3:0] TRAIN_CTRL_RESET = 4'h9;
  // Reset values of the page registers
  localparam logic [15:0] LOCAL_NP_LOW_RESET = 16'h0000;
  localparam logic [31:0] LOCAL_NP_HIGH_RESET = 32'h00000000;
  localparam logic [31:0] PARTNER_RESET = 32'h00000000;
endpackage

/* File: verilog/partner_pages_if.sv */
`timescale 1ns/1ps
interface partner_pages_if;
  // Captured partner pages; a base page updates base and ability words, a next page the next page words
  logic [15:0] base_low;
  logic [31:0] base_high;
  logic [15:0] np_low;
  logic [31:0] np_high;
  logic [31:0] adv;
  logic page_loaded;
  modport src (
    output base_low, base_high, np_low, np_high, adv, page_loaded
  );
  modport dst (
    input base_low, base_high, np_low, np_high, adv, page_loaded
  );
endinterface

/* File: verilog/partner_page_capture.sv */
`timescale 1ns/1ps
module partner_page_capture (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Page handed over by the receive state machine
  input wire logic rx_page_valid,
  input wire logic rx_page_base,
  input wire logic [an_page_pkg::PAGE_W-1:0] rx_page,
  // Captured pages
  partner_pages_if.src pages
);
  import an_page_pkg::*;

  logic [15:0] base_low, next_base_low;
  logic [31:0] base_high, next_base_high;
  logic [15:0] np_low, next_np_low;
  logic [31:0] np_high, next_np_high;
  logic [31:0] adv, next_adv;
  logic loaded, next_loaded;

  // Whole page is taken in one cycle, never field by field
  always_comb begin
    next_base_low = base_low;
    next_base_high = base_high;
    next_np_low = np_low;
    next_np_high = np_high;
    next_adv = adv;
    next_loaded = rx_page_valid;
    if (rx_page_valid && rx_page_base) begin
      next_base_low = rx_page[PAGE_LOW_MSB:0];
      next_base_high = {2'h0, rx_page[PAGE_BASE_HIGH_MSB:PAGE_HIGH_LSB]};
      next_adv = {1'h0, rx_page[CODE_PAUSE_MSB:CODE_PAUSE_LSB],
                  rx_page[CODE_RF_BIT],
                  rx_page[PAGE_HIGH_MSB:CODE_FEC_LSB],
                  rx_page[PAGE_BASE_HIGH_MSB:CODE_TECH_LSB]};
    end else if (rx_page_valid) begin
      next_np_low = rx_page[PAGE_LOW_MSB:0];
      next_np_high = rx_page[PAGE_HIGH_MSB:PAGE_HIGH_LSB];
    end
  end

  // Capture registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      base_low <= PARTNER_RESET[15:0];
      base_high <= PARTNER_RESET;
      np_low <= PARTNER_RESET[15:0];
      np_high <= PARTNER_RESET;
      adv <= PARTNER_RESET;
      loaded <= 1'b0;
    end else begin
      base_low <= next_base_low;
      base_high <= next_base_high;
      np_low <= next_np_low;
      np_high <= next_np_high;
      adv <= next_adv;
      loaded <= next_loaded;
    end
  end

  assign pages.base_low = base_low;
  assign pages.base_high = base_high;
  assign pages.np_low = np_low;
  assign pages.np_high = np_high;
  assign pages.adv = adv;
  assign pages.page_loaded = loaded;
endmodule // partner_page_capture

/* File: verilog/local_next_page.sv */
`timescale 1ns/1ps
module local_next_page (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register writes
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [31:0] wdata,
  // Stored values
  output logic [15:0] np_low,
  output logic [31:0] np_high
);
  import an_page_pkg::*;

  logic [15:0] next_np_low;
  logic [31:0] next_np_high;

  // Software is the only writer; the transmit side only reads
  always_comb begin
    next_np_low = np_low;
    next_np_high = np_high;
    if (wr_low) begin
      next_np_low = wdata[15:0];
    end
    if (wr_high) begin
      next_np_high = wdata;
    end
  end

  // Page storage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      np_low <= LOCAL_NP_LOW_RESET;
      np_high <= LOCAL_NP_HIGH_RESET;
    end else begin
      np_low <= next_np_low;
      np_high <= next_np_high;
    end
  end
endmodule // local_next_page

/* File: verilog/an_page_link_training_regs.sv */
`timescale 1ns/1ps
module an_page_link_training_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [an_page_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [an_page_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [an_page_pkg::DATA_W-1:0] reg_rdata,
  // Transmit state machine
  input wire logic next_page_ctrl,
  output logic tx_np_select,
  output logic [an_page_pkg::PAGE_W-1:0] tx_np_page,
  // Receive state machine
  input wire logic rx_page_valid,
  input wire logic rx_page_base,
  input wire logic [an_page_pkg::PAGE_W-1:0] rx_page,
  // Ability resolution
  output logic [an_page_pkg::TECH_W-1:0] common_tech,
  // Training control
  output logic training_enable,
  output logic max_wait_disable,
  output logic fast_search,
  output logic multi_min_search
);
  import an_page_pkg::*;

  // One address compare used by both write and read decode
  function automatic logic hit(
    input logic [ADDR_W-1:0] addr,
    input logic [7:0] ofs
  );
    hit = (addr == ofs);
  endfunction

  logic [15:0] local_np_low;
  logic [31:0] local_np_high;
  logic [3:0] train_ctrl, next_train_ctrl;
  logic [DATA_W-1:0] next_rdata;
  logic [TECH_W-1:0] next_common_tech;
  logic [PAGE_W-1:0] next_tx_page;
  logic [PAGE_W-1:0] tx_page;
  logic tx_sel, next_tx_sel;
  logic [TECH_W-1:0] tech_reg;
  logic wr_np_low;
  logic wr_np_high;
  logic wr_train;

  partner_pages_if pages ();

  // Write decode; reads of RO offsets have no side effect
  // A write aimed at a read-only offset matches no decode and is lost
  assign wr_np_low = reg_wr && hit(reg_addr, OFS_LOCAL_NP_LOW);
  assign wr_np_high = reg_wr && hit(reg_addr, OFS_LOCAL_NP_HIGH);
  assign wr_train = reg_wr && hit(reg_addr, OFS_TRAIN_CTRL);

  // Local next page storage
  local_next_page u_local_np (
    .core_clk (core_clk),
    .rst_n (rst_n),
    .wr_low (wr_np_low),
    .wr_high (wr_np_high),
    .wdata (reg_wdata),
    .np_low (local_np_low),
    .np_high (local_np_high)
  );

  // Partner page capture
  partner_page_capture u_capture (
    .core_clk (core_clk),
    .rst_n (rst_n),
    .rx_page_valid (rx_page_valid),
    .rx_page_base (rx_page_base),
    .rx_page (rx_page),
    .pages (pages.src)
  );

  // Outgoing next page; bits 48 and 49 are left to the transmitter
  // so the random bit can never be forced by software
  always_comb begin
    next_tx_sel = next_page_ctrl;
    next_tx_page = tx_page;
    if (next_page_ctrl) begin
      next_tx_page = {local_np_high, local_np_low};
    end
  end

  // Training control bits
  // Bits 31:4 of a write are dropped, so they always read back as zero
  always_comb begin
    next_train_ctrl = train_ctrl;
    if (wr_train) begin
      next_train_ctrl = reg_wdata[3:0];
    end
  end

  // Partner technologies that both sides can run
  // Registered, so the result lags the ability register by one cycle
  always_comb begin
    next_common_tech = pages.adv[TECH_W-1:0] & TECH_SUPPORTED;
  end

  // Read mux; unmapped offsets and reserved bits read zero
  // Zero outside a read cycle, so a stale word is never left on the bus
  always_comb begin
    next_rdata = '0;
    if (reg_rd) begin
      case (1'b1)
        hit(reg_addr, OFS_LOCAL_NP_LOW): begin
          next_rdata = {16'h0000, local_np_low};
        end
        hit(reg_addr, OFS_LOCAL_NP_HIGH): begin
          next_rdata = local_np_high;
        end
        hit(reg_addr, OFS_PARTNER_BASE_LOW): begin
          next_rdata = {16'h0000, pages.base_low};
        end
        hit(reg_addr, OFS_PARTNER_BASE_HIGH): begin
          next_rdata = pages.base_high;
        end
        hit(reg_addr, OFS_PARTNER_NP_LOW): begin
          next_rdata = {16'h0000, pages.np_low};
        end
        hit(reg_addr, OFS_PARTNER_NP_HIGH): begin
          next_rdata = pages.np_high;
        end
        hit(reg_addr, OFS_PARTNER_ADV): begin
          next_rdata = pages.adv;
        end
        hit(reg_addr, OFS_TRAIN_CTRL): begin
          next_rdata = {28'h0000000, train_ctrl};
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  // Registered state of this level
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      train_ctrl <= TRAIN_CTRL_RESET;
      reg_rdata <= '0;
      tx_page <= '0;
      tx_sel <= 1'b0;
      tech_reg <= '0;
    end else begin
      train_ctrl <= next_train_ctrl;
      reg_rdata <= next_rdata;
      tx_page <= next_tx_page;
      tx_sel <= next_tx_sel;
      tech_reg <= next_common_tech;
    end
  end

  // Outputs straight from flip-flops
  assign tx_np_select = tx_sel;
  assign tx_np_page = tx_page;
  assign common_tech = tech_reg;
  assign training_enable = train_ctrl[TRN_ENABLE_BIT];
  assign max_wait_disable = train_ctrl[TRN_NO_MAX_WAIT_BIT];
  assign fast_search = train_ctrl[TRN_FAST_BIT];
  assign multi_min_search = train_ctrl[TRN_MULTI_MIN_BIT];

  // Checks run on the register clock, quiet during reset
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  chk_tx_page_source: assert property (
    next_page_ctrl |=> tx_np_select &&
      tx_np_page == {$past(local_np_high), $past(local_np_low)}
  ) else $error("transmit page not taken from local registers");

  chk_tx_page_hold: assert property (
    !next_page_ctrl |=> !tx_np_select && $stable(tx_np_page)
  ) else $error("transmit page moved while control bit clear");

  chk_np_low_write: assert property (
    wr_np_low ##1 (reg_rd && hit(reg_addr, OFS_LOCAL_NP_LOW) &&
      !reg_wr) |=> reg_rdata[15:0] == $past(reg_wdata[15:0], 2)
  ) else $error("local low register readback wrong");

  chk_np_high_map: assert property (
    wr_np_high ##1 next_page_ctrl |=>
      tx_np_page[PAGE_HIGH_MSB:PAGE_HIGH_LSB] == $past(reg_wdata, 2)
  ) else $error("local high register not on page bits 47:16");

  chk_base_low_cap: assert property (
    rx_page_valid && rx_page_base |=>
      pages.base_low == $past(rx_page[PAGE_LOW_MSB:0])
  ) else $error("partner base low not captured");

  chk_base_high_cap: assert property (
    rx_page_valid && rx_page_base |=>
      pages.base_high[31:30] == 2'h0 &&
      pages.base_high[29:5] == $past(rx_page[45:21]) &&
      pages.base_high[4:0] == $past(rx_page[20:16])
  ) else $error("partner base high layout wrong");

  chk_np_cap: assert property (
    rx_page_valid && !rx_page_base |=>
      pages.np_low == $past(rx_page[15:0]) &&
      pages.np_high == $past(rx_page[47:16])
  ) else $error("partner next page not captured");

  chk_adv_fields: assert property (
    rx_page_valid && rx_page_base |=>
      pages.adv[24:0] == $past(rx_page[45:21]) &&
      pages.adv[26] == $past(rx_page[47]) &&
      pages.adv[25] == $past(rx_page[46]) &&
      pages.adv[27] == $past(rx_page[13]) &&
      pages.adv[30:28] == $past(rx_page[12:10]) &&
      !pages.adv[31]
  ) else $error("partner ability fields misplaced");

  chk_common_tech: assert property (
    ##1 common_tech == ($past(pages.adv[24:0]) & 25'h0000005)
  ) else $error("unsupported technology reported as common");

  chk_train_write: assert property (
    wr_train |=> training_enable == $past(reg_wdata[0]) &&
      max_wait_disable == $past(reg_wdata[1]) &&
      fast_search == $past(reg_wdata[2]) &&
      multi_min_search == $past(reg_wdata[3])
  ) else $error("training control write lost");

  chk_train_reset: assert property (
    disable iff (1'b0)
    $rose(rst_n) |-> training_enable && multi_min_search &&
      !max_wait_disable && !fast_search
  ) else $error("training control reset value wrong");

  chk_page_atomic: assert property (
    !rx_page_valid |=> $stable(pages.base_low) &&
      $stable(pages.base_high) && $stable(pages.adv) &&
      $stable(pages.np_low) && $stable(pages.np_high)
  ) else $error("partner page changed without a complete page");

  chk_base_keeps_np: assert property (
    rx_page_valid && rx_page_base |=>
      $stable(pages.np_low) && $stable(pages.np_high)
  ) else $error("base page disturbed next page registers");

  chk_read_latency: assert property (
    !reg_rd |=> reg_rdata == '0
  ) else $error("read data present without a read");

  chk_unmapped_zero: assert property (
    reg_rd && !hit(reg_addr, OFS_TRAIN_CTRL) &&
      (reg_addr < OFS_LOCAL_NP_LOW || reg_addr > OFS_PARTNER_ADV)
      |=> reg_rdata == '0
  ) else $error("unmapped offset did not read zero");

  // Readback of every mapped offset returns the value held at the
  // strobe edge; a wrong mux select shows up here before software
  chk_rd_local_low: assert property (
    reg_rd && hit(reg_addr, OFS_LOCAL_NP_LOW) |=>
      reg_rdata == {16'h0000, $past(local_np_low)}
  ) else $error("local low register read wrong");

  chk_rd_local_high: assert property (
    reg_rd && hit(reg_addr, OFS_LOCAL_NP_HIGH) |=>
      reg_rdata == $past(local_np_high)
  ) else $error("local high register read wrong");

  chk_rd_base_low: assert property (
    reg_rd && hit(reg_addr, OFS_PARTNER_BASE_LOW) |=>
      reg_rdata == {16'h0000, $past(pages.base_low)}
  ) else $error("partner base low read wrong");

  chk_rd_base_high: assert property (
    reg_rd && hit(reg_addr, OFS_PARTNER_BASE_HIGH) |=>
      reg_rdata == $past(pages.base_high)
  ) else $error("partner base high read wrong");

  chk_rd_partner_low: assert property (
    reg_rd && hit(reg_addr, OFS_PARTNER_NP_LOW) |=>
      reg_rdata == {16'h0000, $past(pages.np_low)}
  ) else $error("partner next low read wrong");

  chk_rd_partner_high: assert property (
    reg_rd && hit(reg_addr, OFS_PARTNER_NP_HIGH) |=>
      reg_rdata == $past(pages.np_high)
  ) else $error("partner next high read wrong");

  chk_rd_ability: assert property (
    reg_rd && hit(reg_addr, OFS_PARTNER_ADV) |=>
      reg_rdata == $past(pages.adv)
  ) else $error("partner ability read wrong");

  chk_rd_training: assert property (
    reg_rd && hit(reg_addr, OFS_TRAIN_CTRL) |=>
      reg_rdata == {28'h0000000, $past(train_ctrl)}
  ) else $error("training control read wrong");

  // Stored settings only move on a write to their own offset, so a
  // stray strobe elsewhere in the bank cannot retune the link
  chk_local_low_hold: assert property (
    !wr_np_low |=> $stable(local_np_low)
  ) else $error("local low register changed without a write");

  chk_local_high_hold: assert property (
    !wr_np_high |=> $stable(local_np_high)
  ) else $error("local high register changed without a write");

  chk_train_hold: assert property (
    !wr_train |=> $stable(train_ctrl)
  ) else $error("training control changed without a write");

  // A next page must leave the base page and its abilities alone
  chk_np_keeps_base: assert property (
    rx_page_valid && !rx_page_base |=>
      $stable(pages.base_low) && $stable(pages.base_high) &&
      $stable(pages.adv)
  ) else $error("next page disturbed base page registers");

  chk_common_tracks: assert property (
    rx_page_valid && rx_page_base |-> ##2
      common_tech == ($past(rx_page[45:21], 2) & TECH_SUPPORTED)
  ) else $error("common technology does not follow the base page");
endmodule // an_page_link_training_regs

/* File: tb/link_partner_model.sv */
`timescale 1ns/1ps
module link_partner_model (
  // Clock
  input wire logic core_clk,
  // Pages handed over by the receive side
  output logic rx_page_valid,
  output logic rx_page_base,
  output logic [an_page_pkg::PAGE_W-1:0] rx_page
);
  import an_page_pkg::*;
  // Request count is raised only by the task, served count only by the clocked process
  int req_seq = 0;
  int done_seq = 0;
  logic req_base = 1'b0;
  logic [PAGE_W-1:0] req_page = 48'h0;
  // Quiet start so the bank sees a defined level at time zero
  logic valid_q = 1'b0;
  logic base_q = 1'b0;
  logic [PAGE_W-1:0] page_q = 48'h5A5A_A5A5_0F0F;

  // Between pages the bus churns, so a bank that latches without the strobe shows it
  always @(posedge core_clk) begin
    if (req_seq != done_seq) begin
      valid_q <= 1'b1;
      base_q <= req_base;
      page_q <= req_page;
      done_seq <= req_seq;
    end else begin
      valid_q <= 1'b0;
      base_q <= ~base_q;
      page_q <= ~page_q;
    end
  end

  assign rx_page_valid = valid_q;
  assign rx_page_base = base_q;
  assign rx_page = page_q;

  // Hand one whole page over; the strobe stands for one cycle after return
  task automatic send(input logic base, input logic [PAGE_W-1:0] page);
    #1;
    req_base = base;
    req_page = page;
    req_seq++;
    @(posedge core_clk);
  endtask
endmodule // link_partner_model

/* File: tb/an_page_link_training_regs_tb.sv */
`timescale 1ns/1ps
module an_page_link_training_regs_tb;
  import an_page_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic next_page_ctrl = 1'b0;
  logic tx_np_select;
  logic [PAGE_W-1:0] tx_np_page;
  logic rx_page_valid;
  logic rx_page_base;
  logic [PAGE_W-1:0] rx_page;
  logic [TECH_W-1:0] common_tech;
  logic training_enable, max_wait_disable, fast_search, multi_min_search;
  logic [3:0] trn;
  int bad_count = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h4940;
  logic [31:0] d, lo, hi, r;
  logic [47:0] p;
  logic [31:0] e_bl = 32'h0, e_bh = 32'h0, e_nl = 32'h0, e_nh = 32'h0, e_adv = 32'h0;

  // Training outputs gathered in register bit order
  assign trn = {multi_min_search, fast_search, max_wait_disable, training_enable};

  // 20 MHz clock
  always #25 core_clk = ~core_clk;

  an_page_link_training_regs i_an_page_link_training_regs (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .next_page_ctrl(next_page_ctrl),
    .tx_np_select(tx_np_select), .tx_np_page(tx_np_page), .rx_page_valid(rx_page_valid),
    .rx_page_base(rx_page_base), .rx_page(rx_page), .common_tech(common_tech),
    .training_enable(training_enable), .max_wait_disable(max_wait_disable),
    .fast_search(fast_search), .multi_min_search(multi_min_search));

  link_partner_model i_link_partner_model (
    .core_clk(core_clk), .rx_page_valid(rx_page_valid), .rx_page_base(rx_page_base),
    .rx_page(rx_page));

  // Repeatable stimulus source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected ability word from a received base page
  function automatic logic [31:0] adv_of(input logic [47:0] pg);
    return {1'b0, pg[12:10], pg[13], pg[47:46], pg[45:21]};
  endfunction

  task automatic cmp(input string what, input logic [47:0] exp, input logic [47:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // Write then read of one offset with no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] v, output logic [31:0] q);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    // Reset values
    rd(OFS_TRAIN_CTRL, d);
    cmp("train_ctrl_reset", 48'h9, d);
    cmp("train_outs_reset", 48'h9, trn);
    for (int a = 8'hC5; a <= 8'hCB; a++) begin
      rd(8'(a), d);
      cmp("page_reset", 48'h0, d);
    end
    $display("Test reset done");
    // Every training code; upper bits written random and dropped
    for (int i = 0; i < 16; i++) begin
      r = xs();
      wr(OFS_TRAIN_CTRL, {r[31:4], 4'(i)});
      rd(OFS_TRAIN_CTRL, d);
      cmp("train_ctrl", 48'(i), d);
      cmp("train_outs", 48'(i), trn);
    end
    $display("Test training done");
    // Local next page onto the transmit page; bit 49 is not a port of the bank
    @(posedge core_clk);
    next_page_ctrl <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      lo = (k == 0) ? 32'hFFFF_F800 : xs();
      hi = (k == 0) ? 32'hFFFF_FFFF : xs();
      wr_rd(OFS_LOCAL_NP_LOW, lo, d);
      cmp("local_np_low_b2b", {16'h0, lo[15:0]}, d);
      wr(OFS_LOCAL_NP_HIGH, hi);
      repeat (2) @(posedge core_clk);
      #1;
      cmp("tx_np_page", {hi, lo[15:0]}, tx_np_page);
      cmp("tx_np_select", 48'h1, tx_np_select);
      rd(OFS_LOCAL_NP_LOW, d);
      cmp("local_np_low", {16'h0, lo[15:0]}, d);
      rd(OFS_LOCAL_NP_HIGH, d);
      cmp("local_np_high", hi, d);
    end
    // Control low: transmit page holds
    @(posedge core_clk);
    next_page_ctrl <= 1'b0;
    wr(OFS_LOCAL_NP_HIGH, ~hi);
    repeat (3) @(posedge core_clk);
    #1;
    cmp("tx_np_hold", {hi, lo[15:0]}, tx_np_page);
    cmp("tx_np_select_low", 48'h0, tx_np_select);
    $display("Test local page done");
    // Partner pages, base and next interleaved, reads one idle cycle apart
    for (int k = 0; k < 8; k++) begin
      r = xs();
      p = (k < 2) ? 48'hFFFF_FFFF_FFFF : {r[15:0], xs()};
      i_link_partner_model.send(k[1] ^ k[0], p);
      if (k[1] ^ k[0]) begin
        e_bl = {16'h0, p[15:0]};
        e_bh = {2'b00, p[45:16]};
        e_adv = adv_of(p);
      end else begin
        e_nl = {16'h0, p[15:0]};
        e_nh = p[47:16];
      end
      rd(OFS_PARTNER_BASE_LOW, d);
      cmp("partner_base_low", e_bl, d);
      rd(OFS_PARTNER_BASE_HIGH, d);
      cmp("partner_base_high", e_bh, d);
      rd(OFS_PARTNER_NP_LOW, d);
      cmp("partner_np_low", e_nl, d);
      rd(OFS_PARTNER_NP_HIGH, d);
      cmp("partner_np_high", e_nh, d);
      rd(OFS_PARTNER_ADV, d);
      cmp("partner_adv", e_adv, d);
      cmp("common_tech", e_adv[24:0] & 25'h5, common_tech);
    end
    $display("Test partner pages done");
    // Read-only write ignored, unmapped reads zero
    wr(OFS_PARTNER_BASE_LOW, xs());
    rd(OFS_PARTNER_BASE_LOW, d);
    cmp("ro_write", e_bl, d);
    rd(8'hCC, d);
    cmp("unmapped_cc", 48'h0, d);
    rd(8'hC4, d);
    cmp("unmapped_c4", 48'h0, d);
    $display("Test access done");
    // Reset again mid-run: settings and pages return to their reset values
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(OFS_TRAIN_CTRL, d);
    cmp("train_ctrl_rereset", 48'h9, d);
    cmp("train_outs_rereset", 48'h9, trn);
    rd(OFS_PARTNER_ADV, d);
    cmp("partner_adv_rereset", 48'h0, d);
    $display("Test mid-run reset done");
    end_of_test();
  end
endmodule // an_page_link_training_regs_tb
